// File: design/art_pwm_pkg.sv
// Shared constants and carrier types for the 8-bit auto-reload PWM timer.
// Assumes a 32-bit AHB-Lite fabric; each register sits in the low byte of one word.
package art_pwm_pkg;

  // Sizes
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned PRESC_W = 7;
  localparam int unsigned N_CH    = 4;
  localparam int unsigned DIV_W   = 3;
  localparam int unsigned IDX_W   = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DUTY3  = 8'h73;
  localparam logic [IDX_W-1:0] IDX_DUTY2  = 8'h74;
  localparam logic [IDX_W-1:0] IDX_DUTY1  = 8'h75;
  localparam logic [IDX_W-1:0] IDX_DUTY0  = 8'h76;
  localparam logic [IDX_W-1:0] IDX_PWMCTL = 8'h77;
  localparam logic [IDX_W-1:0] IDX_CSR    = 8'h78;
  localparam logic [IDX_W-1:0] IDX_CNT    = 8'h79;
  localparam logic [IDX_W-1:0] IDX_RELOAD = 8'h7A;

  // Fields of timer_control_status
  localparam int unsigned CSR_EXT_SEL = 7;
  localparam int unsigned CSR_DIV_HI  = 6;
  localparam int unsigned CSR_DIV_LO  = 4;
  localparam int unsigned CSR_RUN_EN  = 3;
  localparam int unsigned CSR_FORCE   = 2;
  localparam int unsigned CSR_OIE     = 1;
  localparam int unsigned CSR_OVF     = 0;

  // Fields of pwm_output_control
  localparam int unsigned PWMCTL_OE_LO  = 4;
  localparam int unsigned PWMCTL_POL_LO = 0;

  // Reset values, counter top and unmapped read data
  localparam logic [7:0]  CSR_RESET    = 8'h00;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [7:0]  CNT_TOP      = 8'hFF;
  localparam logic [31:0] RDATA_UNMAP  = 32'h0000_0000;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'h1,
    BUS_WDATA = 2'h2
  } bus_state_e;

  typedef struct packed {
    logic                      ext_sel;
    logic [DIV_W-1:0]          div_sel;
    logic                      run_en;
    logic                      overflow_irq_enable;
    logic                      ovf;
  } csr_s;

  typedef struct packed {
    logic [N_CH-1:0]           oe;
    logic [N_CH-1:0]           pol;
  } pwm_ctl_s;

endpackage : art_pwm_pkg

// File: design/art_pwm_timer.sv
// Auto-reload PWM timer core with an AHB-Lite register slave.
// Assumes one clock; ext_clk_in is a level synchronous to hclk, counted on rising edges.
// How it works
// - Bit 7 of control picks CPU clock (0) or external clock (1) for prescaler.
// - Bits 6:4 divide the prescaler input by two to the field value.
// - Run enable low freezes prescaler and counter; high lets counter advance.
// - Force-reload bit is write-only and always reads back as zero.
// - Writing force-reload one loads counter from reload value and clears prescaler.
// - Overflow interrupt enable gates whether a set overflow flag requests interrupt.
// - Overflow flag sets when counter passes from FFh to the reload value.
// - Reading the control/status register clears the overflow flag.
// - Control/status register is all zeros after reset.
// - Counter access register reads or writes the live counter while running.
// - Reload register value loads into counter on every overflow.
// - On overflow each PWM output goes to its period-start level per polarity.
// - Output enable bits 7:4 connect each PWM channel to its pin.
// - Polarity 0: output high while counter <= compare, low above; 1 inverts.
// - Changing polarity inverts that channel's output without waiting for overflow.
// - Each channel has a duty register setting its second edge; reload sets first.
// - Reload value sets PWM period and resolution; zero gives 256-count period.
// - Hidden compare shadows load from duty registers at each overflow.
// - Counter increments by one on each prescaler output tick.
// - Writing the counter access register also clears the prescaler.
`timescale 1ns/1ps
`default_nettype none

module art_pwm_timer #(
  parameter int unsigned CNT_W   = art_pwm_pkg::CNT_W,
  parameter int unsigned PRESC_W = art_pwm_pkg::PRESC_W,
  parameter int unsigned N_CH    = art_pwm_pkg::N_CH
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output var  logic                   hreadyout,
  output var  logic [31:0]            hrdata,
  output var  logic                   hresp,
  input  wire logic                   ext_clk_in,
  input  wire logic [N_CH-1:0]        gpio_port_out,
  output var  logic [N_CH-1:0]        pwm_channel_pin,
  output var  logic                   overflow_irq
);

  // Widths are fixed by the register layout
  if (CNT_W != art_pwm_pkg::CNT_W || PRESC_W != art_pwm_pkg::PRESC_W ||
      N_CH != art_pwm_pkg::N_CH) begin : g_bad_params
    $error("art_pwm_timer: only 8-bit counter, 7-bit prescaler, 4 channels supported");
  end

  typedef struct packed {
    art_pwm_pkg::bus_state_e                bus_st;
    logic [art_pwm_pkg::IDX_W-1:0]          wr_idx;
    logic                                   wr_hit;
    art_pwm_pkg::csr_s                      csr;
    art_pwm_pkg::pwm_ctl_s                  pctl;
    logic [CNT_W-1:0]                       cnt;
    logic [PRESC_W-1:0]                     presc;
    logic [CNT_W-1:0]                       reload;
    logic [N_CH-1:0][CNT_W-1:0]             duty;
    logic [N_CH-1:0][CNT_W-1:0]             shadow;
    logic                                   ext_q;
    logic [N_CH-1:0]                        pins;
    logic                                   irq;
    logic                                   readyout;
    logic [31:0]                            rdata;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // Register is mapped when its index lies in the timer window
  function automatic logic is_mapped(input logic [art_pwm_pkg::IDX_W-1:0] idx);
    return idx >= art_pwm_pkg::IDX_DUTY3 && idx <= art_pwm_pkg::IDX_RELOAD;
  endfunction : is_mapped

  // Duty registers sit in descending channel order
  function automatic logic [1:0] duty_chan(input logic [art_pwm_pkg::IDX_W-1:0] idx);
    logic [art_pwm_pkg::IDX_W-1:0] off;
    off = art_pwm_pkg::IDX_DUTY0 - idx;
    return off[1:0];
  endfunction : duty_chan

  function automatic logic is_duty(input logic [art_pwm_pkg::IDX_W-1:0] idx);
    return idx >= art_pwm_pkg::IDX_DUTY3 && idx <= art_pwm_pkg::IDX_DUTY0;
  endfunction : is_duty

  // PWM compare per channel
  logic [N_CH-1:0] pwm_wave;
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    assign pwm_wave[i] = (s_r.cnt <= s_r.shadow[i]) ^ s_r.pctl.pol[i];
  end

  logic                          addr_take;
  logic [art_pwm_pkg::IDX_W-1:0] a_idx;
  logic                          csr_rd;
  logic                          wr_now;
  logic                          cnt_wr;
  logic                          force_wr;
  logic                          in_tick;
  logic                          cnt_tick;
  logic                          ovf_evt;
  logic [PRESC_W-1:0]            tap_mask;
  logic [7:0]                    rd_byte;
  logic [7:0]                    wbyte;

  always_comb begin
    s_nxt     = s_r;
    addr_take = hsel && hready && htrans == art_pwm_pkg::HTRANS_NONSEQ;
    a_idx     = haddr[art_pwm_pkg::IDX_W+1:2];
    wbyte     = hwdata[7:0];
    wr_now    = s_r.bus_st == art_pwm_pkg::BUS_WDATA && s_r.wr_hit;
    cnt_wr    = wr_now && s_r.wr_idx == art_pwm_pkg::IDX_CNT;
    force_wr  = wr_now && s_r.wr_idx == art_pwm_pkg::IDX_CSR &&
                wbyte[art_pwm_pkg::CSR_FORCE];
    csr_rd    = addr_take && !hwrite && a_idx == art_pwm_pkg::IDX_CSR;

    // Prescaler input: CPU clock every cycle, external on its rising edge
    s_nxt.ext_q = ext_clk_in;
    in_tick     = s_r.csr.ext_sel ? (ext_clk_in && !s_r.ext_q) : 1'b1;
    tap_mask    = PRESC_W'((8'h01 << s_r.csr.div_sel) - 8'h01);
    cnt_tick    = s_r.csr.run_en && in_tick &&
                  ((s_r.presc & tap_mask) == tap_mask);
    ovf_evt     = cnt_tick && s_r.cnt == art_pwm_pkg::CNT_TOP && !cnt_wr && !force_wr;

    // Counter and prescaler
    if (s_r.csr.run_en && in_tick) begin
      s_nxt.presc = s_r.presc + PRESC_W'(1);
    end
    if (ovf_evt) begin
      s_nxt.cnt    = s_r.reload;
      s_nxt.shadow = s_r.duty;
    end else if (cnt_tick) begin
      s_nxt.cnt = s_r.cnt + CNT_W'(1);
    end
    if (cnt_wr) begin
      s_nxt.cnt   = wbyte;
      s_nxt.presc = '0;
    end
    if (force_wr) begin
      s_nxt.cnt   = s_r.reload;
      s_nxt.presc = '0;
    end

    // Bus slave: reads answer with no wait, writes take one wait cycle
    s_nxt.readyout = 1'b1;
    case (s_r.bus_st)
      art_pwm_pkg::BUS_IDLE: begin
        if (addr_take && hwrite) begin
          s_nxt.bus_st   = art_pwm_pkg::BUS_WDATA;
          s_nxt.wr_idx   = a_idx;
          s_nxt.wr_hit   = is_mapped(a_idx) && haddr[1:0] == 2'h0;
          s_nxt.readyout = 1'b0;
        end
      end
      art_pwm_pkg::BUS_WDATA: begin
        s_nxt.bus_st = art_pwm_pkg::BUS_IDLE;
        s_nxt.wr_hit = 1'b0;
      end
      default: begin
        s_nxt.bus_st = art_pwm_pkg::BUS_IDLE;
      end
    endcase

    // Register writes
    if (wr_now) begin
      if (is_duty(s_r.wr_idx)) begin
        s_nxt.duty[duty_chan(s_r.wr_idx)] = wbyte;
      end
      case (s_r.wr_idx)
        art_pwm_pkg::IDX_PWMCTL: begin
          s_nxt.pctl.oe  = wbyte[art_pwm_pkg::PWMCTL_OE_LO +: 4];
          s_nxt.pctl.pol = wbyte[art_pwm_pkg::PWMCTL_POL_LO +: 4];
        end
        art_pwm_pkg::IDX_CSR: begin
          s_nxt.csr.ext_sel = wbyte[art_pwm_pkg::CSR_EXT_SEL];
          s_nxt.csr.div_sel = wbyte[art_pwm_pkg::CSR_DIV_HI:art_pwm_pkg::CSR_DIV_LO];
          s_nxt.csr.run_en  = wbyte[art_pwm_pkg::CSR_RUN_EN];
          s_nxt.csr.overflow_irq_enable     = wbyte[art_pwm_pkg::CSR_OIE];
        end
        art_pwm_pkg::IDX_RELOAD: begin
          s_nxt.reload = wbyte;
        end
        default: begin
        end
      endcase
    end

    // Register reads, captured in the address phase
    rd_byte = art_pwm_pkg::REG_RESET;
    if (is_duty(a_idx)) begin
      rd_byte = s_r.duty[duty_chan(a_idx)];
    end
    case (a_idx)
      art_pwm_pkg::IDX_PWMCTL: rd_byte = {s_r.pctl.oe, s_r.pctl.pol};
      art_pwm_pkg::IDX_CSR:    rd_byte = {s_r.csr.ext_sel, s_r.csr.div_sel, s_r.csr.run_en,
                                          1'b0, s_r.csr.overflow_irq_enable, s_r.csr.ovf};
      art_pwm_pkg::IDX_CNT:    rd_byte = s_r.cnt;
      art_pwm_pkg::IDX_RELOAD: rd_byte = s_r.reload;
      default: begin
      end
    endcase
    if (addr_take && !hwrite) begin
      s_nxt.rdata = (is_mapped(a_idx) && haddr[1:0] == 2'h0) ? {24'h00_0000, rd_byte}
                                                              : art_pwm_pkg::RDATA_UNMAP;
    end

    // Overflow flag: a new overflow wins over the clearing read
    if (csr_rd) begin
      s_nxt.csr.ovf = 1'b0;
    end
    if (ovf_evt) begin
      s_nxt.csr.ovf = 1'b1;
    end
    s_nxt.irq = s_nxt.csr.ovf && s_nxt.csr.overflow_irq_enable;

    // Pins: waveform when enabled, port data otherwise
    for (int i = 0; i < N_CH; i++) begin
      s_nxt.pins[i] = s_r.pctl.oe[i] ? pwm_wave[i] : gpio_port_out[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r.bus_st   <= art_pwm_pkg::BUS_IDLE;
      s_r.wr_idx   <= '0;
      s_r.wr_hit   <= 1'b0;
      s_r.csr      <= art_pwm_pkg::CSR_RESET[6:0];
      s_r.pctl     <= art_pwm_pkg::REG_RESET;
      s_r.cnt      <= '0;
      s_r.presc    <= '0;
      s_r.reload   <= '0;
      s_r.duty     <= '0;
      s_r.shadow   <= '0;
      s_r.ext_q    <= 1'b0;
      s_r.pins     <= '0;
      s_r.irq      <= 1'b0;
      s_r.readyout <= 1'b1;
      s_r.rdata    <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout       = s_r.readyout;
  assign hrdata          = s_r.rdata;
  assign hresp           = art_pwm_pkg::HRESP_OKAY;
  assign pwm_channel_pin = s_r.pins;
  assign overflow_irq    = s_r.irq;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic unused_ok;
  assign unused_ok = ^hsize;

  a_irq_gating: assert property (overflow_irq == (s_r.csr.ovf && s_r.csr.overflow_irq_enable))
    else $error("interrupt line does not follow flag and enable");

  a_force_reads_zero: assert property (csr_rd |=> !hrdata[art_pwm_pkg::CSR_FORCE])
    else $error("force-reload bit read back as one");

  a_ovf_sets_flag: assert property (ovf_evt |=> s_r.csr.ovf && s_r.cnt == $past(s_r.reload))
    else $error("overflow did not set flag and reload counter");

  a_read_clears_flag: assert property (csr_rd && !ovf_evt |=> !s_r.csr.ovf)
    else $error("status read did not clear overflow flag");

  a_stopped_holds: assert property (!s_r.csr.run_en && !cnt_wr && !force_wr
                                    |=> $stable(s_r.cnt) && $stable(s_r.presc))
    else $error("counter moved while stopped");

  a_shadow_load: assert property (ovf_evt |=> s_r.shadow == $past(s_r.duty))
    else $error("compare shadows not loaded on overflow");

  a_div_one_step: assert property (s_r.csr.run_en && !s_r.csr.ext_sel && s_r.csr.div_sel == 3'h0
                                   && !cnt_wr && !force_wr && s_r.cnt != art_pwm_pkg::CNT_TOP
                                   |=> s_r.cnt == $past(s_r.cnt) + 8'h01)
    else $error("counter did not step at undivided rate");

  a_count_write: assert property (cnt_wr |=> s_r.cnt == $past(hwdata[7:0]) && s_r.presc == '0)
    else $error("counter write did not load value and clear prescaler");

  a_pin_disabled: assert property (!s_r.pctl.oe[0] |=> pwm_channel_pin[0] == $past(gpio_port_out[0]))
    else $error("disabled pin not under port control");

  // Counter loading and prescaler
  a_force_reload: assert property (force_wr |=> s_r.cnt == $past(s_r.reload)
                                   && s_r.presc == '0)
    else $error("forced reload did not load counter and clear prescaler");

  a_presc_step: assert property (s_r.csr.run_en && in_tick && !cnt_wr && !force_wr
                                 |=> s_r.presc == $past(s_r.presc) + 7'h01)
    else $error("prescaler did not advance on an input tick");

  a_ext_waits: assert property (s_r.csr.ext_sel && !(ext_clk_in && !s_r.ext_q)
                                && !cnt_wr && !force_wr
                                |=> $stable(s_r.presc) && $stable(s_r.cnt))
    else $error("counting moved without an external clock rise");

  a_wrap_full: assert property (ovf_evt && s_r.reload == 8'h00
                                |=> s_r.cnt == 8'h00)
    else $error("zero reload did not restart a full period");

  a_flag_source: assert property ($rose(s_r.csr.ovf) |-> $past(ovf_evt))
    else $error("overflow flag set without an overflow");

  // Reset and register access
  a_reset_clear: assert property (@(posedge hclk) disable iff (1'b0)
                                  !hresetn |-> s_r.csr == '0 && s_r.cnt == '0
                                  && overflow_irq == 1'b0)
    else $error("state not cleared during reset");

  a_count_read: assert property (a_idx == art_pwm_pkg::IDX_CNT
                                 && addr_take && !hwrite && haddr[1:0] == 2'h0
                                 |=> hrdata[7:0] == $past(s_r.cnt))
    else $error("counter read did not return the live count");

  a_duty_write: assert property (wr_now && is_duty(s_r.wr_idx)
                                 |=> s_r.duty[duty_chan($past(s_r.wr_idx))] == $past(wbyte))
    else $error("duty register write lost");

  a_reload_write: assert property (wr_now && s_r.wr_idx == art_pwm_pkg::IDX_RELOAD
                                   |=> s_r.reload == $past(wbyte))
    else $error("reload register write lost");

  a_irq_quiet: assert property (!s_r.csr.overflow_irq_enable || !s_r.csr.ovf |-> !overflow_irq)
    else $error("interrupt raised without flag and enable");

  // Pin behaviour per channel
  for (genvar i = 0; i < N_CH; i++) begin : g_pin_chk
    a_pin_enabled: assert property (s_r.pctl.oe[i]
                                    |=> pwm_channel_pin[i] == $past(pwm_wave[i]))
      else $error("enabled pin does not carry its waveform");

    a_level_rule: assert property (s_r.pctl.oe[i] && s_r.cnt <= s_r.shadow[i]
                                   |=> pwm_channel_pin[i] == !$past(s_r.pctl.pol[i]))
      else $error("pin level does not follow compare and polarity");

    a_period_start: assert property (ovf_evt && s_r.pctl.oe[i]
                                     && s_r.reload <= s_r.duty[i] ##1 $stable(s_r.pctl)
                                     |=> pwm_channel_pin[i] == !$past(s_r.pctl.pol[i]))
      else $error("pin not at period-start level after overflow");

    a_pol_flip: assert property ($changed(s_r.pctl.pol[i])
                                 && s_r.pctl.oe[i] && $stable(s_r.pctl.oe[i])
                                 && $stable(s_r.cnt) && $stable(s_r.shadow[i])
                                 |=> pwm_channel_pin[i] != $past(pwm_channel_pin[i]))
      else $error("polarity change did not invert the pin at once");
  end

  c_overflow:   cover property (ovf_evt ##1 overflow_irq);
  c_read_clear: cover property (s_r.csr.ovf && csr_rd ##1 !s_r.csr.ovf);
  c_force:      cover property (force_wr);
  c_ext_tick:   cover property (s_r.csr.ext_sel && cnt_tick);
  c_full_range: cover property (ovf_evt && s_r.reload == 8'h00);

endmodule : art_pwm_timer

`default_nettype wire

// File: test/pwm_auto_reload_timer_regs_tb.sv
// Self-checking bench for the auto-reload PWM timer register slave.
// Assumes one AHB-Lite master (this bench) and the timer as the only slave.
`timescale 1ns/1ps
`default_nettype none

module pwm_auto_reload_timer_regs_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_clk_in, ext_on;
  logic        overflow_irq;
  wire logic   hready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  gpio_port_out, pwm_channel_pin;
  logic [7:0]  rd;
  int          bad_count, comparisons, hi, per, n;

  assign hready = hreadyout;

  art_pwm_timer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_clk_in(ext_clk_in),
    .gpio_port_out(gpio_port_out), .pwm_channel_pin(pwm_channel_pin),
    .overflow_irq(overflow_irq)
  );

  always #2.5 hclk = ~hclk;

  // External count clock: one rise every two hclk cycles while enabled
  always @(posedge hclk) begin
    if (ext_on) begin
      ext_clk_in <= ~ext_clk_in;
    end
  end

  task automatic complete_run();
    $display("COUNTS comparisons=%0d bad=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic give_up();
    bad_count++;
    $display("BAD wait expected event seen none");
    complete_run();
  endtask : give_up

  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) give_up();
  endtask : wait_ready

  // One single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= art_pwm_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {24'h0, d};
    wait_ready();
    rd = hrdata[7:0];
  endtask : bus

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic chkn(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chkn

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk8("register read", exp, rd);
  endtask : rdchk

  task automatic idle(input int k);
    repeat (k) @(posedge hclk);
  endtask : idle

  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (pwm_channel_pin[0] !== v && c < 2000);
    if (pwm_channel_pin[0] !== v) give_up();
  endtask : wait_lvl

  // High time and period of channel 0, from one full rise to the next
  task automatic measure();
    int lo;
    wait_lvl(1'b0, lo);
    wait_lvl(1'b1, lo);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    per = hi + lo;
  endtask : measure

  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; ext_clk_in = 1'b0; ext_on = 1'b0;
    gpio_port_out = 4'hA; bad_count = 0; comparisons = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (n = 8'h73; n <= 8'h7B; n++) begin
      rdchk(8'(n), 8'h00);
    end
    $display("TEST reset values done");
    bus(1'b1, art_pwm_pkg::IDX_RELOAD, 8'hFC);
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h04);
    rdchk(art_pwm_pkg::IDX_CSR, 8'h00);
    rdchk(art_pwm_pkg::IDX_CNT, 8'hFC);
    bus(1'b1, 8'h7B, 8'h55);
    rdchk(art_pwm_pkg::IDX_RELOAD, 8'hFC);
    rdchk(8'h7B, 8'h00);
    bus(1'b1, art_pwm_pkg::IDX_CNT, 8'h37);
    rdchk(art_pwm_pkg::IDX_CNT, 8'h37);
    idle(20);
    rdchk(art_pwm_pkg::IDX_CNT, 8'h37);
    $display("TEST force reload and counter access done");
    bus(1'b1, art_pwm_pkg::IDX_DUTY0, 8'hFD);
    bus(1'b1, art_pwm_pkg::IDX_PWMCTL, 8'h10);
    bus(1'b1, art_pwm_pkg::IDX_CNT, 8'hFC);
    for (n = 0; n < 8; n++) begin
      bus(1'b1, art_pwm_pkg::IDX_CSR, {1'b0, 3'(n), 4'h8});
      measure();
      chkn("high time", 2 << n, hi);
      chkn("period", 4 << n, per);
    end
    ext_on <= 1'b1;
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h88);
    measure();
    chkn("external high time", 4, hi);
    chkn("external period", 8, per);
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h00);
    ext_on <= 1'b0;
    $display("TEST divider and clock source done");
    rdchk(art_pwm_pkg::IDX_CSR, 8'h01);
    rdchk(art_pwm_pkg::IDX_CSR, 8'h00);
    bus(1'b1, art_pwm_pkg::IDX_CNT, 8'hFF);
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h0A);
    idle(4);
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h02);
    idle(1);
    chk8("irq enabled", 8'h01, {7'h0, overflow_irq});
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h00);
    idle(1);
    chk8("irq masked", 8'h00, {7'h0, overflow_irq});
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h02);
    idle(1);
    chk8("irq unmasked", 8'h01, {7'h0, overflow_irq});
    rdchk(art_pwm_pkg::IDX_CSR, 8'h03);
    idle(1);
    chk8("irq after clear", 8'h00, {7'h0, overflow_irq});
    $display("TEST overflow flag and interrupt done");
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h04);
    idle(2);
    chk8("pins oe0", 8'h0B, {4'h0, pwm_channel_pin});
    bus(1'b1, art_pwm_pkg::IDX_PWMCTL, 8'h11);
    idle(2);
    chk8("pins inverted", 8'h0A, {4'h0, pwm_channel_pin});
    bus(1'b1, art_pwm_pkg::IDX_PWMCTL, 8'hF0);
    idle(2);
    chk8("pins all on", 8'h01, {4'h0, pwm_channel_pin});
    bus(1'b1, art_pwm_pkg::IDX_PWMCTL, 8'h00);
    idle(2);
    chk8("pins all off", 8'h0A, {4'h0, pwm_channel_pin});
    $display("TEST output enable and polarity done");
    bus(1'b1, art_pwm_pkg::IDX_PWMCTL, 8'h10);
    bus(1'b1, art_pwm_pkg::IDX_DUTY0, 8'h00);
    idle(2);
    chk8("pins before reload", 8'h0B, {4'h0, pwm_channel_pin});
    bus(1'b1, art_pwm_pkg::IDX_CNT, 8'hFF);
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h08);
    idle(3);
    bus(1'b1, art_pwm_pkg::IDX_CSR, 8'h00);
    idle(2);
    chk8("pins after reload", 8'h0A, {4'h0, pwm_channel_pin});
    $display("TEST duty double buffer done");
    complete_run();
  end
endmodule : pwm_auto_reload_timer_regs_tb

`default_nettype wire
